//--- rtl/mmd_memory_map_decoder.sv
// Purpose: Address decode, chip selects, byte strobes and board control pins.
// Assumes: Host bus signals are synchronous to clk; board pins are not.
// Notes:   Peripheral registers sit on the upper byte lane, lower lane reads zero.
`timescale 1ns/1ps

module mmd_memory_map_decoder (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   ce,
    input  wire mmd_pkg::mmd_bus_req_type busReq,
    input  wire logic [15:0]            busDataIn,
    output logic [15:0]                 busDataOut,
    output logic                        busDataOutEn,
    output logic                        busReadyN,
    output mmd_pkg::mmd_selects_type    selects,
    output logic                        readHighByteN,
    output logic                        writeHighByteN,
    output logic                        readLowByteN,
    output logic                        writeLowByteN,
    input  wire logic                   powerFailN,
    input  wire logic                   progSupplyReq,
    output logic                        prog_supply_enable,
    input  wire logic                   clockIrqInN,
    output logic                        clockIrqOutN,
    input  wire logic                   serialTxIn,
    output logic                        serialTxOut,
    output logic                        display_clock,
    input  wire logic                   displayResetReqN,
    output logic                        display_reset_n,
    input  wire logic [7:0]             digitalInPins,
    input  wire logic [7:0]             keypadCode,
    output logic [7:0]                  digitalOutPins,
    output logic [3:0]                  alarmOutPins,
    output logic                        keypadScanEnable,
    output logic                        runMapActive
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Bit layout of the synchronised pin vector
    localparam int PIN_PWR  = 0;
    localparam int PIN_PROG = 1;
    localparam int PIN_IRQ  = 2;
    localparam int PIN_TX   = 3;
    localparam int PIN_DISPLAY_RESET_N = 4;
    localparam int PIN_DI   = 5;
    localparam int PIN_KP   = 13;
    localparam int NPINS    = 21;
    localparam logic [NPINS-1:0] PIN_IDLE = 21'h00001C;

    logic [NPINS-1:0] pinRaw;
    logic [NPINS-1:0] pinSyncA_r;
    logic [NPINS-1:0] pinSyncB_r;
    logic [NPINS-1:0] pinSyncC_r;
    logic [NPINS-1:0] pinStable_r;

    assign pinRaw = {keypadCode, digitalInPins, displayResetReqN,
                     serialTxIn, clockIrqInN, progSupplyReq, powerFailN};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinSyncA_r <= PIN_IDLE;
            pinSyncB_r <= PIN_IDLE;
            pinSyncC_r <= PIN_IDLE;
        end else if (ce) begin
            pinSyncA_r <= pinRaw;
            pinSyncB_r <= pinSyncA_r;
            pinSyncC_r <= pinSyncB_r;
        end
    end

    // A change counts once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : gPinFilter
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    pinStable_r[gi] <= PIN_IDLE[gi];
                end else if (ce && (pinSyncB_r[gi] == pinSyncC_r[gi])) begin
                    pinStable_r[gi] <= pinSyncC_r[gi];
                end
            end
        end
    endgenerate

    logic       powerOk;
    logic [7:0] digitalInSync;
    logic [7:0] keypadSync;

    assign powerOk       = pinStable_r[PIN_PWR];
    assign digitalInSync = pinStable_r[PIN_DI +: 8];
    assign keypadSync    = pinStable_r[PIN_KP +: 8];

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] control_r;
    logic [7:0] control_nxt;
    logic [7:0] alarm_r;
    logic [7:0] alarm_nxt;
    logic [7:0] digOut_r;
    logic [7:0] digOut_nxt;
    logic       runMap;

    assign runMap = control_r[mmd_pkg::CTL_RUN_MAP_BIT];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [23:0] addr;
    logic        accessOn;
    logic        inLowMem;
    logic        inHighMem;
    logic        inCfgRange;
    logic        inClock;
    logic        inOption;
    logic        inCard;
    logic        inIoRegion;
    logic        hitFlash;
    logic        hitSram;
    logic        hitCfg;
    logic [23:0] windowBase;
    logic        ctlAddr;
    logic        winControl;
    logic        winAlarm;
    logic        winDigOut;
    logic        winDigIn;
    logic        winKeypad;
    logic        anyWindow;

    assign addr       = busReq.addr;
    assign accessOn   = !busReq.addrStrobeN;
    assign inLowMem   = (addr >= mmd_pkg::LOW_MEM_LO) && (addr <= mmd_pkg::LOW_MEM_HI);
    assign inHighMem  = (addr >= mmd_pkg::HIGH_MEM_LO) && (addr <= mmd_pkg::HIGH_MEM_HI);
    assign inCfgRange = (addr >= mmd_pkg::CFG_PORT_LO) && (addr <= mmd_pkg::CFG_PORT_HI);
    assign inClock    = (addr >= mmd_pkg::CLOCK_LO) && (addr <= mmd_pkg::CLOCK_HI);
    assign inOption   = (addr >= mmd_pkg::OPTION_LO) && (addr <= mmd_pkg::OPTION_HI);
    assign inCard     = (addr >= mmd_pkg::CARD_LO) && (addr <= mmd_pkg::CARD_HI);
    assign inIoRegion = (addr >= mmd_pkg::IO_REGION_LO) && (addr <= mmd_pkg::IO_REGION_HI);

    // Flash low and SRAM high while booting, swapped once the run map is on
    assign hitFlash = runMap ? inHighMem : inLowMem;
    assign hitSram  = runMap ? inLowMem : inHighMem;
    assign hitCfg   = !runMap && inCfgRange;

    // Eight-byte windows exist only in the run map; control writes decode in both maps
    assign windowBase = {addr[23:mmd_pkg::WINDOW_LSB], 3'h0};
    assign ctlAddr    = (windowBase == mmd_pkg::CONTROL_STATUS_ADDR);
    assign winControl = runMap && ctlAddr;
    assign winAlarm   = runMap && (windowBase == mmd_pkg::ALARM_OUTPUTS_ADDR);
    assign winDigOut  = runMap && (windowBase == mmd_pkg::DIGITAL_OUTPUTS_ADDR);
    assign winDigIn   = runMap && (windowBase == mmd_pkg::DIGITAL_INPUTS_ADDR);
    assign winKeypad  = runMap && (windowBase == mmd_pkg::KEYPAD_INPUT_ADDR);
    assign anyWindow  = winControl || winAlarm || winDigOut || winDigIn || winKeypad;

    // ------------------------------------------------------------------
    // Chip selects and byte strobes
    // ------------------------------------------------------------------
    logic upperRead;
    logic upperWrite;
    logic lowerRead;
    logic lowerWrite;

    assign upperRead  = accessOn && busReq.readNotWrite && !busReq.upperStrobeN;
    assign upperWrite = accessOn && !busReq.readNotWrite && !busReq.upperStrobeN;
    assign lowerRead  = accessOn && busReq.readNotWrite && !busReq.lowerStrobeN;
    assign lowerWrite = accessOn && !busReq.readNotWrite && !busReq.lowerStrobeN;

    assign readHighByteN  = !upperRead;
    assign writeHighByteN = !upperWrite;
    assign readLowByteN   = !lowerRead;
    assign writeLowByteN  = !lowerWrite;

    // Unlisted addresses leave every select high
    assign selects.flashSelN  = !(accessOn && hitFlash);
    assign selects.sramSelN   = !(accessOn && hitSram && powerOk);
    assign selects.cfgSelN    = !(accessOn && hitCfg);
    assign selects.clockSelN  = !(accessOn && inClock && powerOk);
    assign selects.optionSelN = !(accessOn && inOption);
    assign selects.cardSelN   = !(accessOn && inCard);

    // ------------------------------------------------------------------
    // Access sequencer and wait states
    // ------------------------------------------------------------------
    mmd_pkg::mmd_acc_state_type accState_r;
    mmd_pkg::mmd_acc_state_type accState_nxt;
    logic [1:0] waitCnt_r;
    logic [1:0] waitCnt_nxt;
    logic       memAccess;
    logic       regStrobe;

    assign memAccess = hitFlash || hitSram;

    always_comb begin
        accState_nxt = accState_r;
        waitCnt_nxt  = waitCnt_r;
        regStrobe    = 1'b0;
        case (accState_r)
            mmd_pkg::ACC_IDLE: begin
                // The cycle that first sees the strobe is the first wait state
                waitCnt_nxt = 2'h1;
                if (accessOn && inIoRegion) begin
                    accState_nxt = mmd_pkg::ACC_WAIT;
                end
            end
            mmd_pkg::ACC_WAIT: begin
                if (!accessOn) begin
                    accState_nxt = mmd_pkg::ACC_IDLE;
                end else if (waitCnt_r == mmd_pkg::IO_WAIT_STATES - 2'h1) begin
                    accState_nxt = mmd_pkg::ACC_DONE;
                    regStrobe    = 1'b1;
                end else begin
                    waitCnt_nxt = waitCnt_r + 2'h1;
                end
            end
            mmd_pkg::ACC_DONE: begin
                if (!accessOn) begin
                    accState_nxt = mmd_pkg::ACC_IDLE;
                end
            end
            default: begin
                accState_nxt = mmd_pkg::ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accState_r <= mmd_pkg::ACC_IDLE;
            waitCnt_r  <= 2'h0;
        end else if (ce) begin
            accState_r <= accState_nxt;
            waitCnt_r  <= waitCnt_nxt;
        end
    end

    // Memory answers at once, I/O after the wait states
    assign busReadyN = !(accessOn && (memAccess ||
                        (accState_r == mmd_pkg::ACC_DONE)));

    // ------------------------------------------------------------------
    // Register writes on the upper byte lane
    // ------------------------------------------------------------------
    logic       regWrite;
    logic [7:0] wrByte;

    assign regWrite = regStrobe && upperWrite;
    assign wrByte   = busDataIn[15:8];

    // Only writable windows take data; input windows are left alone
    // Remap writes land in both maps so boot code can leave the boot map;
    // configuration bytes must therefore avoid the first eight port bytes
    assign control_nxt = (regWrite && ctlAddr) ?
                         (wrByte & mmd_pkg::CTL_WRITE_MASK) : control_r;
    assign alarm_nxt   = (regWrite && winAlarm) ?
                         (wrByte & mmd_pkg::ALARM_MASK) : alarm_r;
    assign digOut_nxt  = (regWrite && winDigOut) ? wrByte : digOut_r;

    // The remap bit at the control window is the only map state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            control_r <= mmd_pkg::CTL_RESET;
            alarm_r   <= mmd_pkg::ALARM_RESET;
            digOut_r  <= mmd_pkg::DIG_OUT_RESET;
        end else if (ce) begin
            control_r <= control_nxt;
            alarm_r   <= alarm_nxt;
            digOut_r  <= digOut_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    logic [7:0] statusByte;
    logic [7:0] rdByte;
    logic       regRead;

    assign statusByte = control_r |
                        (8'(powerOk) << mmd_pkg::STS_POWER_OK_BIT) |
                        (8'(!display_reset_n) << mmd_pkg::STS_DISP_RESET_BIT);
    assign rdByte = winControl ? statusByte :
                    winAlarm   ? alarm_r :
                    winDigOut  ? digOut_r :
                    winDigIn   ? digitalInSync :
                    winKeypad  ? keypadSync : mmd_pkg::REG_ZERO;
    assign regRead = accessOn && busReq.readNotWrite && anyWindow;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busDataOut   <= 16'h0000;
            busDataOutEn <= 1'b0;
        end else if (ce) begin
            busDataOut   <= {rdByte, mmd_pkg::REG_ZERO};
            busDataOutEn <= regRead;
        end
    end

    // ------------------------------------------------------------------
    // Board control pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prog_supply_enable <= 1'b0;
            clockIrqOutN       <= 1'b1;
            serialTxOut        <= 1'b1;
            display_reset_n    <= 1'b0;
        end else if (ce) begin
            prog_supply_enable <= pinStable_r[PIN_PROG];
            clockIrqOutN       <= pinStable_r[PIN_IRQ];
            serialTxOut        <= pinStable_r[PIN_TX];
            display_reset_n    <= pinStable_r[PIN_DISPLAY_RESET_N];
        end
    end

    assign digitalOutPins   = digOut_r;
    assign alarmOutPins     = alarm_r[3:0];
    assign keypadScanEnable = control_r[mmd_pkg::CTL_KEYPAD_EN_BIT];
    assign runMapActive     = runMap;

    // ------------------------------------------------------------------
    // Display clock
    // ------------------------------------------------------------------
    mmd_display_clock uDisplayClock (
        .clk          (clk),
        .resetn       (resetn),
        .ce           (ce),
        .displayClock (display_clock)
    );

endmodule : mmd_memory_map_decoder

//--- rtl/mmd_pkg.sv
// Purpose: Shared constants and types for the main board memory map decoder.
// Assumes: 24-bit byte addresses from the host, 16-bit data bus, 25 MHz clock.
// Notes:   Peripheral registers are eight bits wide and sit on the upper byte lane.
package mmd_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REG_W  = 8;

    // ------------------------------------------------------------------
    // Address ranges, inclusive bounds
    // ------------------------------------------------------------------
    localparam logic [23:0] LOW_MEM_LO   = 24'h000000;
    localparam logic [23:0] LOW_MEM_HI   = 24'h03FFFF;
    localparam logic [23:0] HIGH_MEM_LO  = 24'h100000;
    localparam logic [23:0] HIGH_MEM_HI  = 24'h13FFFF;
    localparam logic [23:0] CFG_PORT_LO  = 24'h300000;
    localparam logic [23:0] CFG_PORT_HI  = 24'h30007F;
    localparam logic [23:0] CLOCK_LO     = 24'h300080;
    localparam logic [23:0] CLOCK_HI     = 24'h3000FF;
    localparam logic [23:0] OPTION_LO    = 24'h300100;
    localparam logic [23:0] OPTION_HI    = 24'h30017F;
    localparam logic [23:0] CARD_LO      = 24'h310000;
    localparam logic [23:0] CARD_HI      = 24'h311FFF;
    localparam logic [23:0] IO_REGION_LO = 24'h300000;
    localparam logic [23:0] IO_REGION_HI = 24'h30FFFF;

    // ------------------------------------------------------------------
    // Register windows, eight bytes each, in the run-time map
    // ------------------------------------------------------------------
    localparam logic [23:0] CONTROL_STATUS_ADDR  = 24'h300000;
    localparam logic [23:0] ALARM_OUTPUTS_ADDR   = 24'h300008;
    localparam logic [23:0] DIGITAL_OUTPUTS_ADDR = 24'h300010;
    localparam logic [23:0] DIGITAL_INPUTS_ADDR  = 24'h300018;
    localparam logic [23:0] KEYPAD_INPUT_ADDR    = 24'h300020;
    localparam int          WINDOW_LSB           = 3;

    // ------------------------------------------------------------------
    // Control/status fields and reset values
    // ------------------------------------------------------------------
    localparam int CTL_RUN_MAP_BIT    = 0;
    localparam int CTL_KEYPAD_EN_BIT  = 1;
    localparam int STS_POWER_OK_BIT   = 6;
    localparam int STS_DISP_RESET_BIT = 7;
    localparam logic [7:0] CTL_WRITE_MASK  = 8'h03;
    localparam logic [7:0] CTL_RESET       = 8'h00;
    localparam logic [7:0] ALARM_MASK      = 8'h0F;
    localparam logic [7:0] ALARM_RESET     = 8'h00;
    localparam logic [7:0] DIG_OUT_RESET   = 8'h00;
    localparam logic [7:0] REG_ZERO        = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ        = 25_000_000;
    localparam int          DISP_CLK_HZ   = 1_024_000;
    localparam logic [1:0]  IO_WAIT_STATES = 2'h2;
    localparam logic [15:0] DISP_ACC_MOD  = 16'(CLK_HZ / 1000);
    localparam logic [15:0] DISP_ACC_STEP = 16'(DISP_CLK_HZ / 1000);
    // Display clock is high for the last third of each period
    localparam logic [15:0] DISP_HIGH_AT  = 16'((2 * (CLK_HZ / 1000)) / 3);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_DONE = 2'b10
    } mmd_acc_state_type;

    typedef struct packed {
        logic [23:0] addr;
        logic        readNotWrite;
        logic        upperStrobeN;
        logic        lowerStrobeN;
        logic        addrStrobeN;
    } mmd_bus_req_type;

    typedef struct packed {
        logic flashSelN;
        logic sramSelN;
        logic cfgSelN;
        logic clockSelN;
        logic optionSelN;
        logic cardSelN;
    } mmd_selects_type;

endpackage : mmd_pkg

//--- rtl/mmd_display_clock.sv
// Purpose: Fractional divider making the display clock from the system clock.
// Assumes: Clock rate far above the display clock rate.
// Notes:   Phase accumulator; period jitters by one system clock cycle.
`timescale 1ns/1ps
module mmd_display_clock (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    output logic      displayClock
);

    // ------------------------------------------------------------------
    // Phase accumulator
    // ------------------------------------------------------------------
    logic [15:0] phase_r;
    logic [15:0] phase_nxt;
    logic [15:0] phaseSum;
    logic        clkHigh;

    assign phaseSum  = phase_r + mmd_pkg::DISP_ACC_STEP;
    assign phase_nxt = (phaseSum >= mmd_pkg::DISP_ACC_MOD) ?
                       phaseSum - mmd_pkg::DISP_ACC_MOD : phaseSum;
    // Low for two thirds, high for one third
    assign clkHigh   = (phase_nxt >= mmd_pkg::DISP_HIGH_AT);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r      <= 16'h0000;
            displayClock <= 1'b0;
        end else if (ce) begin
            phase_r      <= phase_nxt;
            displayClock <= clkHigh;
        end
    end

endmodule : mmd_display_clock

//--- bench/mmd_host_model.sv
// Purpose: Host processor side of the board bus, one access at a time.
// Assumes: Answer is taken at the rising edge where ready is low.
// Notes:   Released address and data lines show the inverse of their last value; control lines go high.
`timescale 1ns/1ps
module mmd_host_model (
    input  wire logic                     clk,
    input  wire logic                     busReadyN,
    input  wire logic [15:0]              busDataOut,
    input  wire mmd_pkg::mmd_selects_type selects,
    output mmd_pkg::mmd_bus_req_type      busReq,
    output logic [15:0]                   busDataIn
);
    initial begin
        busReq = '{24'h000000, 1'b1, 1'b1, 1'b1, 1'b1};
        busDataIn = 16'h0000;
    end
    // Lower lane is written only in memory space
    task automatic acc(input logic [23:0] a, input logic rw, input logic [15:0] wd,
                       output logic [15:0] rd, output mmd_pkg::mmd_selects_type s,
                       output int n);
        n = 0;
        @(posedge clk);
        busReq <= '{a, rw, 1'b0, rw | a[21], 1'b0};
        busDataIn <= rw ? ~busDataIn : wd;
        do begin
            @(posedge clk);
            s = selects;
            rd = busDataOut;
            n++;
        end while (busReadyN !== 1'b0 && n < 9);
        busReq <= '{~a, 1'b1, 1'b1, 1'b1, 1'b1};
        busDataIn <= ~busDataIn;
    endtask : acc
endmodule : mmd_host_model

//--- bench/mmd_assertions.sv
// Purpose: Port-level checks on decode, strobes, gating and pin copies.
// Assumes: One clock domain, reset active low.
// Notes:   Attached to the decoder by bind.
`timescale 1ns/1ps
module mmd_assertions (
    input wire logic                     clk,
    input wire logic                     resetn,
    input wire mmd_pkg::mmd_bus_req_type busReq,
    input wire logic                     busReadyN,
    input wire mmd_pkg::mmd_selects_type selects,
    input wire logic                     readHighByteN,
    input wire logic                     writeHighByteN,
    input wire logic                     readLowByteN,
    input wire logic                     writeLowByteN,
    input wire logic                     busDataOutEn,
    input wire logic                     powerFailN,
    input wire logic                     serialTxIn,
    input wire logic                     serialTxOut,
    input wire logic                     runMapActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic accOn = !busReq.addrStrobeN;
    boot_flash_a: assert property (accOn && !runMapActive && busReq.addr <= 24'h03FFFF
        |-> !selects.flashSelN) else $error("boot flash select missing");
    run_flash_a: assert property (accOn && runMapActive && busReq.addr[23:18] == 6'h04
        |-> !selects.flashSelN) else $error("run flash select missing");
    cfg_boot_a: assert property (!selects.cfgSelN |-> accOn && !runMapActive)
        else $error("config select outside boot map");
    upper_read_a: assert property (accOn && busReq.readNotWrite && !busReq.upperStrobeN
        |-> !readHighByteN) else $error("upper read strobe missing");
    lower_write_a: assert property (!writeLowByteN
        |-> accOn && !busReq.readNotWrite && !busReq.lowerStrobeN) else $error("stray write");
    power_gate_a: assert property (!powerFailN [*6]
        |-> selects.sramSelN && selects.clockSelN) else $error("select not gated");
    io_wait_a: assert property ($fell(busReq.addrStrobeN) && busReq.addr[23:16] == 8'h30
        |-> busReadyN ##1 busReadyN ##1 !busReadyN) else $error("io wait count wrong");
    mem_ready_a: assert property (accOn && !selects.flashSelN |-> !busReadyN)
        else $error("flash access waited");
    unlisted_a: assert property (accOn && busReq.addr[23:20] == 4'h2 |-> &selects)
        else $error("select in empty space");
    serial_a: assert property ($fell(serialTxIn) |-> ##[1:6] !serialTxOut)
        else $error("serial low not passed");
    upper_write_a: assert property (accOn && !busReq.readNotWrite && !busReq.upperStrobeN
        |-> !writeHighByteN) else $error("upper write strobe missing");
    lower_read_a: assert property (accOn && !busReq.readNotWrite |-> readLowByteN)
        else $error("lower read during write");
    read_data_en_a: assert property (accOn && busReq.readNotWrite && runMapActive
        && busReq.addr >= 24'h300000 && busReq.addr <= 24'h300027 |=> busDataOutEn)
        else $error("register read not driven");
endmodule : mmd_assertions
bind mmd_memory_map_decoder mmd_assertions chk (.clk, .resetn, .busReq, .busReadyN, .selects,
    .readHighByteN, .writeHighByteN, .readLowByteN, .writeLowByteN, .busDataOutEn,
    .powerFailN, .serialTxIn, .serialTxOut, .runMapActive);

//--- bench/mmd_memory_map_decoder_tb.sv
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Host model drives the bus; pins are driven here.
// Notes:   Wait count is cycles from strobe to ready.
`timescale 1ns/1ps
module mmd_memory_map_decoder_tb;
    logic clk = 0, resetn = 0, powerFailN = 1, progSupplyReq = 0, clockIrqInN = 1;
    logic serialTxIn = 1, displayResetReqN = 1;
    logic [7:0] digitalInPins = 8'h96, keypadCode = 8'h5A, digitalOutPins;
    logic [15:0] busDataIn, busDataOut, rd;
    logic [3:0] alarmOutPins;
    logic busDataOutEn, busReadyN, readHighByteN, writeHighByteN, readLowByteN, writeLowByteN;
    logic prog_supply_enable, clockIrqOutN, serialTxOut, display_clock, display_reset_n;
    logic keypadScanEnable, runMapActive;
    mmd_pkg::mmd_bus_req_type busReq;
    mmd_pkg::mmd_selects_type selects, s;
    int errorCnt = 0, totalChecks = 0, dclkCnt = 0, n;
    always #20 clk = ~clk;
    always @(posedge display_clock) dclkCnt++;
    mmd_host_model host (.clk, .busReadyN, .busDataOut, .selects, .busReq, .busDataIn);
    mmd_memory_map_decoder dut (.clk, .resetn, .ce(1'b1), .busReq, .busDataIn, .busDataOut,
        .busDataOutEn, .busReadyN, .selects, .readHighByteN, .writeHighByteN, .readLowByteN,
        .writeLowByteN, .powerFailN, .progSupplyReq, .prog_supply_enable, .clockIrqInN,
        .clockIrqOutN, .serialTxIn, .serialTxOut, .display_clock, .displayResetReqN,
        .display_reset_n, .digitalInPins, .keypadCode, .digitalOutPins, .alarmOutPins,
        .keypadScanEnable, .runMapActive);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Read one address, compare selects and, when w >= 0, the wait count
    task automatic dec(input logic [23:0] a, input logic [5:0] e, input int w);
        host.acc(a, 1'b1, 16'h0000, rd, s, n);
        chk(8'(s), 8'(e));
        if (w >= 0) chk(8'(n - 1), 8'(w));
    endtask : dec
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        host.acc(a, 1'b0, d, rd, s, n);
    endtask : wr
    task automatic boot_map;
        chk({prog_supply_enable, serialTxOut, display_reset_n, clockIrqOutN}, 8'h05);
        dec(24'h000000, 6'h1F, 0);
        dec(24'h03FFFF, 6'h1F, 0);
        dec(24'h13FFFF, 6'h2F, 0);
        dec(24'h30007F, 6'h37, 2);
        dec(24'h300080, 6'h3B, 2);
        dec(24'h30017F, 6'h3D, 2);
        dec(24'h311FFF, 6'h3E, 8);
        dec(24'h140000, 6'h3F, 8);
        chk(runMapActive, 1'b0);
    endtask : boot_map
    task automatic run_map;
        wr(24'h300000, 16'h0300);
        chk({runMapActive, keypadScanEnable}, 8'h03);
        dec(24'h000000, 6'h2F, 0);
        dec(24'h13FFFF, 6'h1F, 0);
        dec(24'h3000FF, 6'h3B, 2);
        dec(24'h300000, 6'h3F, 2);
    endtask : run_map
    task automatic regs;
        wr(24'h300008, 16'hA500);
        wr(24'h300010, 16'h3C00);
        wr(24'h300018, 16'hFF00);
        wr(24'h300020, 16'hFF00);
        chk({alarmOutPins, 4'h0}, 8'h50);
        chk(digitalOutPins, 8'h3C);
        dec(24'h30000F, 6'h3F, 2);
        chk(rd[15:8], 8'h05);
        dec(24'h300018, 6'h3F, 2);
        chk(rd[15:8], 8'h96);
        dec(24'h300020, 6'h3F, 2);
        chk(rd[15:8], 8'h5A);
    endtask : regs
    task automatic power_and_pins;
        powerFailN <= 1'b0;
        repeat (8) @(posedge clk);
        dec(24'h000000, 6'h3F, -1);
        dec(24'h300080, 6'h3F, -1);
        powerFailN <= 1'b1;
        progSupplyReq <= 1'b1;
        serialTxIn <= 1'b0;
        displayResetReqN <= 1'b0;
        clockIrqInN <= 1'b0;
        repeat (8) @(posedge clk);
        wr(24'h100000, 16'h1234);
        chk({prog_supply_enable, serialTxOut, display_reset_n, clockIrqOutN}, 8'h08);
        progSupplyReq <= 1'b0;
        serialTxIn <= 1'b1;
        displayResetReqN <= 1'b1;
        clockIrqInN <= 1'b1;
        repeat (8) @(posedge clk);
        chk({prog_supply_enable, serialTxOut, display_reset_n, clockIrqOutN}, 8'h07);
    endtask : power_and_pins
    task automatic disp_clock;
        dclkCnt = 0;
        repeat (25000) @(posedge clk);
        chk(8'(dclkCnt inside {[1023:1025]}), 8'h01);
    endtask : disp_clock
    task automatic giveVerdict;
        if (errorCnt == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : giveVerdict
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        boot_map();
        run_map();
        regs();
        power_and_pins();
        disp_clock();
        giveVerdict();
    end
    initial begin
        repeat (40000) @(posedge clk);
        errorCnt++;
        giveVerdict();
    end
endmodule : mmd_memory_map_decoder_tb
